// [sar_adc_serial_readout.sv]
// Purpose: control of an 18-bit successive-approximation converter and its serial readout
// Assumes: comparator decisions arrive on cmp_decision in step with ref_clk; shift_clk is the host clock
// Notes: result crosses to the shift domain by a toggle handshake with a stable data word
`timescale 1ns/1ps
`include "sar_readout_defs.svh"
module sar_adc_serial_readout
  import sar_readout_pkg::*;
(
  input wire logic ref_clk, // internal converter clock
  input wire logic rst_n, // asynchronous reset, active low
  input wire logic power_down_n_pin, // low shuts the device down
  input wire logic test_pattern_select, // high selects the fixed pattern
  input wire logic dual_lane_select, // high selects two lanes
  input wire logic convert_start, // rising edge starts a conversion
  input wire logic cmp_decision, // comparator: input above trial level
  input wire logic shift_clk, // host shift clock
  output logic sample_hold, // high while the sampler holds
  output logic data_ready, // high once the current result is ready
  output logic echoed_data_clock, // copy of the shift clock, held low while powered down
  output logic echoed_data_clock_oe, // driver enable of the echo clock
  output logic lane_a_data, // serial data lane a
  output logic lane_a_oe, // driver enable of lane a
  output logic lane_b_data, // serial data lane b
  output logic lane_b_oe // driver enable of lane b
);
  // pin synchronisers into ref_clk
  logic [1:0] pd_sync_q, pd_sync_d;
  logic [1:0] cnv_sync_q, cnv_sync_d;
  logic cnv_prev_q, cnv_prev_d;
  logic cmp_sync1_q, cmp_sync2_q;
  logic cmp_sync1_d, cmp_sync2_d;
  logic [1:0] dual_ref_sync_q, dual_ref_sync_d;
  phase_e phase_q, phase_d;
  code_t trial_q, trial_d;
  code_t result_q, result_d;
  logic [4:0] bit_idx_q, bit_idx_d;
  logic result_tgl_q, result_tgl_d;
  logic ready_q, ready_d;
  logic cnv_rise;
  logic powered;

  // decision of one approximation step on the given bit, in two's complement
  function automatic code_t sar_step(input code_t trial, input logic [4:0] idx, input logic above);
    code_t t;
    t = trial;
    if (idx == 5'd17) begin
      t[17] = ~above; // sign bit set means below midscale
    end else begin
      t[idx] = above;
    end
    if (idx != 5'd0) begin
      t[idx - 5'd1] = 1'b1;
    end
    return t;
  endfunction

  // synchroniser next values
  always_comb begin
    pd_sync_d = {pd_sync_q[0], power_down_n_pin};
    cnv_sync_d = {cnv_sync_q[0], convert_start};
    cnv_prev_d = cnv_sync_q[1];
    // comparator and lane select follow the same two-flop path
    cmp_sync1_d = cmp_decision;
    cmp_sync2_d = cmp_sync1_q;
    dual_ref_sync_d = {dual_ref_sync_q[0], dual_lane_select};
  end

  // synchroniser registers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pd_sync_q <= 2'b00;
      cnv_sync_q <= 2'b00;
      cnv_prev_q <= 1'b0;
      cmp_sync1_q <= 1'b0;
      cmp_sync2_q <= 1'b0;
      dual_ref_sync_q <= 2'b00;
    end else begin
      pd_sync_q <= pd_sync_d;
      cnv_sync_q <= cnv_sync_d;
      cnv_prev_q <= cnv_prev_d;
      cmp_sync1_q <= cmp_sync1_d;
      cmp_sync2_q <= cmp_sync2_d;
      dual_ref_sync_q <= dual_ref_sync_d;
    end
  end

  assign powered = pd_sync_q[1];
  assign cnv_rise = cnv_sync_q[1] & ~cnv_prev_q;

  // phase sequencer and approximation register
  always_comb begin
    phase_d = phase_q;
    trial_d = trial_q;
    result_d = result_q;
    bit_idx_d = bit_idx_q;
    result_tgl_d = result_tgl_q;
    ready_d = ready_q;
    if (!powered) begin
      phase_d = PH_POWERED_DOWN;
      ready_d = 1'b0;
    end else begin
      unique case (phase_q)
        PH_POWERED_DOWN: begin
          phase_d = PH_ACQUIRE;
        end
        PH_ACQUIRE: begin
          if (cnv_rise) begin
            phase_d = PH_CONVERT;
            trial_d = `SAR_START_CODE;
            bit_idx_d = 5'd17;
            ready_d = 1'b0;
          end
        end
        PH_CONVERT: begin
          trial_d = sar_step(trial_q, bit_idx_q, cmp_sync2_q);
          if (bit_idx_q == 5'd0) begin
            result_d = sar_step(trial_q, bit_idx_q, cmp_sync2_q);
            result_tgl_d = ~result_tgl_q;
            ready_d = 1'b1;
            phase_d = PH_ACQUIRE;
          end else begin
            bit_idx_d = bit_idx_q - 5'd1;
          end
        end
        default: begin
          phase_d = PH_ACQUIRE;
        end
      endcase
    end
  end

  // sequencer registers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_q <= PH_POWERED_DOWN;
      trial_q <= 18'h0_0000;
      result_q <= 18'h0_0000;
      bit_idx_q <= 5'd0;
      result_tgl_q <= 1'b0;
      ready_q <= 1'b0;
    end else begin
      phase_q <= phase_d;
      trial_q <= trial_d;
      result_q <= result_d;
      bit_idx_q <= bit_idx_d;
      result_tgl_q <= result_tgl_d;
      ready_q <= ready_d;
    end
  end

  assign sample_hold = (phase_q == PH_CONVERT);
  assign data_ready = ready_q;

  // shift-domain state: toggle synchroniser and shift register
  logic [1:0] tgl_sync_q, tgl_sync_d;
  logic tgl_seen_q, tgl_seen_d;
  logic [1:0] lpd_sync_q, lpd_sync_d;
  code_t shreg_q, shreg_d;
  logic la_q, la_d;
  logic lb_q, lb_d;
  logic [1:0] tp_sync_q, tp_sync_d;
  logic [1:0] dsel_sync_q, dsel_sync_d;
  logic tp_sel, dual_sel;
  logic load_now;
  code_t load_word;

  // static selects cross into the shift domain through two flops; the host holds them across a readout
  assign tp_sel = tp_sync_q[1];
  assign dual_sel = dsel_sync_q[1];
  // a new word is taken only once the power state has crossed as well
  assign load_now = lpd_sync_q[1] && (tgl_sync_q[1] != tgl_seen_q);
  assign load_word = tp_sel ? `TEST_PATTERN : result_q;

  // next values of the shift domain
  always_comb begin
    tgl_sync_d = {tgl_sync_q[0], result_tgl_q};
    lpd_sync_d = {lpd_sync_q[0], power_down_n_pin};
    tp_sync_d = {tp_sync_q[0], test_pattern_select};
    dsel_sync_d = {dsel_sync_q[0], dual_lane_select};
    tgl_seen_d = tgl_seen_q;
    shreg_d = shreg_q;
    la_d = la_q;
    lb_d = lb_q;
    if (!lpd_sync_q[1]) begin
      // powered down: the shifter is cleared and a pending word is dropped
      tgl_seen_d = tgl_sync_q[1];
      shreg_d = 18'h0_0000;
      la_d = 1'b0;
      lb_d = 1'b0;
    end else if (load_now) begin
      // new word: result_q is stable since the toggle crossed
      tgl_seen_d = tgl_sync_q[1];
      shreg_d = load_word;
      la_d = load_word[17];
      lb_d = dual_sel ? load_word[16] : 1'b0;
    end else if (dual_sel) begin
      shreg_d = {shreg_q[15:0], 2'b00};
      la_d = shreg_q[15];
      lb_d = shreg_q[14];
    end else begin
      shreg_d = {shreg_q[16:0], 1'b0};
      la_d = shreg_q[16];
      lb_d = 1'b0;
    end
  end

  // shift-domain registers, advanced by every host clock rise
  always_ff @(posedge shift_clk or negedge rst_n) begin
    if (!rst_n) begin
      tgl_sync_q <= 2'b00;
      lpd_sync_q <= 2'b00;
      tp_sync_q <= 2'b00;
      dsel_sync_q <= 2'b00;
      tgl_seen_q <= 1'b0;
      shreg_q <= 18'h0_0000;
      la_q <= 1'b0;
      lb_q <= 1'b0;
    end else begin
      tgl_sync_q <= tgl_sync_d;
      lpd_sync_q <= lpd_sync_d;
      tp_sync_q <= tp_sync_d;
      dsel_sync_q <= dsel_sync_d;
      tgl_seen_q <= tgl_seen_d;
      shreg_q <= shreg_d;
      la_q <= la_d;
      lb_q <= lb_d;
    end
  end

  // output drivers
  assign echoed_data_clock = powered & shift_clk;
  assign echoed_data_clock_oe = powered;
  assign lane_a_data = la_q;
  assign lane_a_oe = powered;
  assign lane_b_data = lb_q;
  assign lane_b_oe = powered & dual_ref_sync_q[1];

  // assertions on the converter side
  AST_PD_DRIVERS_OFF: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !powered |-> (!lane_a_oe && !lane_b_oe && !echoed_data_clock_oe))
    else $error("drivers enabled while powered down");
  AST_LANE_B_OFF: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (!dual_lane_select [*3]) |-> !lane_b_oe)
    else $error("lane b driven in one-lane mode");
  AST_START_HOLD: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (cnv_rise && phase_q == PH_ACQUIRE && powered) |=> sample_hold)
    else $error("convert start did not enter hold");
  AST_CONV_LEN: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ($rose(sample_hold) && powered) |-> ##17 (sample_hold && bit_idx_q == 5'd0))
    else $error("conversion length wrong");
  AST_READY_AFTER: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (sample_hold && bit_idx_q == 5'd0 && powered) |=> (data_ready && !sample_hold))
    else $error("result not ready at conversion end");
  AST_TGL_ON_READY: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(data_ready) |-> (result_tgl_q != $past(result_tgl_q)))
    else $error("result handoff not signalled");
  AST_SIGN_BIT: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (sample_hold && bit_idx_q == 5'd17 && powered) |=> (trial_q[17] == !$past(cmp_sync2_q)))
    else $error("sign bit not two's complement");
  AST_NOT_READY_IN_CONV: assert property (@(posedge ref_clk) disable iff (!rst_n)
    sample_hold |-> !data_ready)
    else $error("ready raised during conversion");
  AST_PD_NO_HOLD: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !powered |=> !sample_hold)
    else $error("conversion running while powered down");

  // assertions on the shift side
  AST_LOAD_MSB_FIRST: assert property (@(posedge shift_clk) disable iff (!rst_n)
    load_now |=> (shreg_q == $past(load_word) && lane_a_data == shreg_q[17]))
    else $error("new word not loaded msb first");
  AST_PATTERN_WORD: assert property (@(posedge shift_clk) disable iff (!rst_n)
    (load_now && tp_sel) |=> (shreg_q == `TEST_PATTERN))
    else $error("test pattern not loaded");
  AST_DUAL_STEP: assert property (@(posedge shift_clk) disable iff (!rst_n)
    (lpd_sync_q[1] && !load_now && dual_sel) |=> (shreg_q == {$past(shreg_q[15:0]), 2'b00}))
    else $error("two-lane step did not move two bits");
  AST_ONE_LANE_B_LOW: assert property (@(posedge shift_clk) disable iff (!rst_n)
    !dual_sel |=> !lane_b_data)
    else $error("lane b carries data in one-lane mode");
  AST_PD_SHIFT_CLEAR: assert property (@(posedge shift_clk) disable iff (!rst_n)
    !lpd_sync_q[1] |=> (shreg_q == 18'h0_0000 && !lane_a_data && !lane_b_data))
    else $error("shifter active while powered down");
  AST_ECHO_FOLLOWS: assert property (@(negedge shift_clk) disable iff (!rst_n)
    powered |-> echoed_data_clock)
    else $error("echo clock missed a shift clock pulse");
endmodule

// [sar_readout_defs.svh]
// Purpose: timing and layout constants for the converter serial readout
// Assumes: ref_clk at 10 MHz (100 ns period)
// Notes: times in ns, cycle counts derived from them
`ifndef SAR_READOUT_DEFS_SVH
`define SAR_READOUT_DEFS_SVH
`define RES_BITS 18
`define CLK_PERIOD_NS 100
`define CONV_MIN_NS 67
`define CONV_MAX_NS 78
// least time rounds up, never below one cycle
`define CONV_CYCLES (((`CONV_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS) < 1 ? 1 : \
  ((`CONV_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS))
`define TEST_PATTERN 18'h2_A5C3
`define SAR_START_CODE 18'h2_0000
`endif

// [sar_readout_pkg.sv]
// Purpose: types for the converter serial readout
// Assumes: nothing beyond the defs header
// Notes: holds the phase enumeration and the 18-bit code type
package sar_readout_pkg;
  typedef enum logic [1:0] {
    PH_POWERED_DOWN = 2'b00,
    PH_ACQUIRE = 2'b01,
    PH_CONVERT = 2'b10
  } phase_e;
  typedef logic [17:0] code_t;
endpackage

// [host_model.sv]
// Purpose: host side that starts conversions and reads the serial word
// Assumes: shift clock bursts of 15 ns period, idle low between bursts
// Notes: lanes are sampled on the falling echo edge, midway between launches
`timescale 1ns/1ps
module host_model
  import sar_readout_pkg::*;
(
  input wire logic ref_clk, // converter clock, times the starts
  input wire logic echoed_data_clock, // echo of the shift clock
  input wire logic lane_a_data, // serial lane a
  input wire logic lane_b_data, // serial lane b
  output logic convert_start, // conversion start
  output logic shift_clk // shift clock, still outside bursts
);
  logic qa[$];
  logic qb[$];
  int n_echo;
  // idle levels
  initial begin
    convert_start = 1'b0;
    shift_clk = 1'b0;
    n_echo = 0;
  end
  // start edge held two cycles so the synchroniser cannot miss it
  task automatic start_conv();
    @(negedge ref_clk) convert_start = 1'b1;
    fork
      begin
        repeat (2) @(negedge ref_clk);
        convert_start = 1'b0;
      end
    join_none
  endtask
  // burst of n pulses, issued whenever called, with no wait for data ready and no check against the next start
  task automatic read_burst(input int n);
    qa.delete();
    qb.delete();
    n_echo = 0;
    #3;
    repeat (n) begin
      #7.5 shift_clk = 1'b1;
      #7.5 shift_clk = 1'b0;
    end
    #5;
  endtask
  // capture with the echo, after the launch at its rise has settled
  always @(negedge echoed_data_clock) begin
    qa.push_back(lane_a_data);
    qb.push_back(lane_b_data);
    n_echo++;
  end
  // rebuild the word from offset k of the capture
  function automatic code_t word(input logic dual, input int k);
    code_t w;
    for (int i = 0; i < 18; i++) begin
      w[17 - i] = dual ? (i[0] ? qb[k + i / 2] : qa[k + i / 2]) : qa[k + i];
    end
    return w;
  endfunction
  // offset binary view for a host that wants it
  function automatic code_t to_offset(input code_t c);
    return c ^ 18'h2_0000;
  endfunction
endmodule

// [tb_top.sv]
// Purpose: self-checking bench for the converter serial readout
// Assumes: comparator held steady for a whole conversion
// Notes: the word is found by its offset in the capture, zero fill must follow
`timescale 1ns/1ps
`include "sar_readout_defs.svh"
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin n_fail++; \
  $display("[FAIL] %s expected %h seen %h", nm, ex, got); end end
module tb_top;
  import sar_readout_pkg::*;
  logic ref_clk, rst_n, power_down_n_pin, test_pattern_select, dual_lane_select, cmp_decision;
  logic convert_start, shift_clk, sample_hold, data_ready, echoed_data_clock, echoed_data_clock_oe;
  logic lane_a_data, lane_a_oe, lane_b_data, lane_b_oe;
  int n_fail = 0;
  int n_tests = 0;
  sar_adc_serial_readout sar_adc_serial_readout_i (.ref_clk(ref_clk), .rst_n(rst_n),
    .power_down_n_pin(power_down_n_pin), .test_pattern_select(test_pattern_select),
    .dual_lane_select(dual_lane_select), .convert_start(convert_start), .cmp_decision(cmp_decision),
    .shift_clk(shift_clk), .sample_hold(sample_hold), .data_ready(data_ready),
    .echoed_data_clock(echoed_data_clock), .echoed_data_clock_oe(echoed_data_clock_oe),
    .lane_a_data(lane_a_data), .lane_a_oe(lane_a_oe), .lane_b_data(lane_b_data), .lane_b_oe(lane_b_oe));
  host_model host_model_i (.ref_clk(ref_clk), .echoed_data_clock(echoed_data_clock),
    .lane_a_data(lane_a_data), .lane_b_data(lane_b_data), .convert_start(convert_start), .shift_clk(shift_clk));
  // converter clock
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  // verdict and end of run
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // one conversion: latencies, then a burst and a search for the word
  task automatic run_conv(input logic cmp, input logic dual, input code_t exp);
    int cnt;
    int held;
    int kk;
    cnt = 0;
    held = 1;
    kk = -1;
    @(negedge ref_clk);
    cmp_decision = cmp;
    dual_lane_select = dual;
    host_model_i.start_conv();
    while (sample_hold !== 1'b1 && cnt < 40) begin
      @(posedge ref_clk);
      #1;
      cnt++;
    end
    `CHK("hold_lat", 3, cnt)
    while (!(data_ready === 1'b1 && sample_hold === 1'b0) && cnt < 60) begin
      @(posedge ref_clk);
      #1;
      cnt++;
      held += (sample_hold === 1'b1);
    end
    `CHK("ready_lat", 21, cnt)
    `CHK("hold_len", 18, held)
    `CHK("lane_b_oe", dual, lane_b_oe)
    `CHK("lane_a_oe", 1'b1, lane_a_oe)
    host_model_i.read_burst(30);
    `CHK("echo_edges", 30, host_model_i.n_echo)
    for (int k = 8; k >= 0; k--) begin
      if (host_model_i.word(dual, k) === exp) kk = k;
    end
    `CHK("word", exp, host_model_i.word(dual, (kk < 0) ? 0 : kk))
    `CHK("fill", 1'b0, host_model_i.qa[((kk < 0) ? 0 : kk) + (dual ? 9 : 18)])
    `CHK("fill_b", 1'b0, host_model_i.qb[((kk < 0) ? 0 : kk) + 9])
  endtask
  // both lane modes, both extreme codes
  task automatic sc_lanes();
    run_conv(1'b0, 1'b0, 18'h2_0000);
    run_conv(1'b1, 1'b0, 18'h1_FFFF);
    run_conv(1'b0, 1'b1, 18'h2_0000);
    run_conv(1'b1, 1'b1, 18'h1_FFFF);
    `CHK("offset", 18'h3_FFFF, host_model_i.to_offset(host_model_i.word(1'b1, 2)))
  endtask
  // fixed pattern replaces the result in both modes
  task automatic sc_pattern();
    @(negedge ref_clk);
    test_pattern_select = 1'b1;
    run_conv(1'b1, 1'b0, `TEST_PATTERN);
    run_conv(1'b0, 1'b1, `TEST_PATTERN);
    @(negedge ref_clk);
    test_pattern_select = 1'b0;
  endtask
  // a start during conversion must not begin another one
  task automatic sc_refused();
    host_model_i.start_conv();
    repeat (8) @(negedge ref_clk);
    `CHK("first_hold", 1'b1, sample_hold)
    host_model_i.start_conv();
    repeat (14) @(negedge ref_clk);
    `CHK("no_restart", 1'b0, sample_hold)
    `CHK("still_ready", 1'b1, data_ready)
    host_model_i.read_burst(30);
  endtask
  // power down silences drivers, echo and starts; power up recovers
  task automatic sc_power_down();
    @(negedge ref_clk);
    power_down_n_pin = 1'b0;
    dual_lane_select = 1'b1;
    repeat (4) @(negedge ref_clk);
    `CHK("pd_a_oe", 1'b0, lane_a_oe)
    `CHK("pd_b_oe", 1'b0, lane_b_oe)
    `CHK("pd_clk_oe", 1'b0, echoed_data_clock_oe)
    host_model_i.start_conv();
    host_model_i.read_burst(6);
    repeat (5) @(negedge ref_clk);
    `CHK("pd_echo", 0, host_model_i.n_echo)
    `CHK("pd_hold", 1'b0, sample_hold)
    power_down_n_pin = 1'b1;
    repeat (6) @(negedge ref_clk);
    `CHK("pu_clk_oe", 1'b1, echoed_data_clock_oe)
    run_conv(1'b1, 1'b0, 18'h1_FFFF);
  endtask
  // reset with both clocks moving, then the scenarios
  initial begin
    rst_n = 1'b0;
    power_down_n_pin = 1'b1;
    test_pattern_select = 1'b0;
    dual_lane_select = 1'b0;
    cmp_decision = 1'b0;
    host_model_i.read_burst(4);
    repeat (10) @(negedge ref_clk);
    rst_n = 1'b1;
    repeat (6) @(negedge ref_clk);
    sc_lanes();
    sc_pattern();
    sc_refused();
    sc_power_down();
    summarize();
  end
  // cut a hang short
  initial begin
    #500000;
    n_fail++;
    $display("watchdog expired");
    summarize();
  end
endmodule
